// >>> verilog/ssp_pkg.sv
// Package with register map, field layout and carrier types of the port.
package ssp_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] SSP_CMD_IDX = 32'h01ff8100;
    localparam logic [31:0] SSP_DATA_IDX = 32'h01ff8102;
    localparam logic [31:0] SSP_DIV_IDX = 32'h01ff8104;
    localparam logic [31:0] SSP_CMD_ADDR = SSP_CMD_IDX << 2;
    localparam logic [31:0] SSP_DATA_ADDR = SSP_DATA_IDX << 2;
    localparam logic [31:0] SSP_DIV_ADDR = SSP_DIV_IDX << 2;

    // ------------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------------
    localparam int SSP_ROLE_POS = 0;
    localparam int SSP_PHASE_POS = 2;
    localparam int SSP_POL_POS = 3;
    localparam int SSP_ORDER_POS = 4;
    localparam int SSP_STATOUT_POS = 8;
    localparam int SSP_FULL_POS = 7;
    localparam int SSP_DIV_W = 4;
    localparam int SSP_BITS = 8;

    // ------------------------------------------------------------------
    // Counts and reset values
    // ------------------------------------------------------------------
    localparam logic [3:0] SSP_LAST_EDGE = 4'hf;
    localparam logic [3:0] SSP_LAST_BIT = 4'h7;
    localparam logic [3:0] SSP_DIV_RST = 4'h0;
    localparam logic [7:0] SSP_BYTE_RST = 8'h00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_RUN = 2'b01
    } ssp_state_e_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } ssp_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } ssp_apb_rsp_t;

    typedef struct packed {
        logic tx_data_pin;
        logic serial_clock_out;
        logic serial_clock_oe;
        logic data_request_pin;
        logic port_status_pin;
        logic rx_full_flag;
    } ssp_pins_t;

    typedef struct packed {
        ssp_state_e_t state;
        logic slave_role_bit;
        logic clock_phase_bit;
        logic clock_polarity_bit;
        logic lsb_first_select;
        logic status_out_value;
        logic [3:0] divisor_field;
        logic [3:0] div_cnt;
        logic [3:0] edge_cnt;
        logic [3:0] bit_cnt;
        logic [7:0] tx_shift_reg;
        logic [7:0] rx_shift_reg;
        logic [7:0] rx_byte;
        logic full;
        logic sclk_lvl;
        logic sclk_prev;
        ssp_pins_t pins;
        ssp_apb_rsp_t rsp;
    } ssp_regs_t;

endpackage

// >>> verilog/ssp_sync_serial_port.sv
// Synchronous serial port with APB register access, master or slave role.
`timescale 1ns/1ps
// Notes on behaviour
// R1: After reset transmit data pin is low and status pin is high.
// R2: Role bit 0 is master driving the clock, 1 is slave.
// R3: Generated clock runs from aux clock/2 to /32, 50% duty.
// R4: Clock rate is aux clock over 2*(divisor+1), divisor in bits 3:0.
// R5: Writing the divisor reloads the divider counter at once.
// R6: Data write clears bit count, loads transmit byte, starts 8-bit shift.
// R7: Data read returns received byte and clears the full flag.
// R8: Divisor bit 7 is read-only full flag, also sent out as interrupt.
// R9: Full flag becomes active on an aux clock edge.
// R10: Command bit 4 picks LSB-first, else MSB-first, both directions.
// R11: Command bit 3 sets clock polarity, ignored in pin I/O mode.
// R12: Phase bit 2 puts first clock edge mid-bit or at bit start.
// R13: Partner samples on rising edge when polarity equals phase.
// R14: One byte each way per transfer over eight clock pulses.
// R15: Partner uses the same polarity and phase as this port.
// R16: Command bit 8 drives the status pin when configured as output.
// R17: In slave role a request/acknowledge handshake is offered.
// R18: After eighth bit, received byte goes to input register, flag set.
// R19: Unused register bits read as zero.
// R20: Idle clock rests at polarity level, eight clock cycles per write.
module ssp_sync_serial_port #(
    parameter int DIV_W = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ssp_pkg::ssp_apb_req_t apb_req,
    output ssp_pkg::ssp_apb_rsp_t apb_rsp,
    input wire logic rx_data_pin,
    input wire logic serial_clock_in,
    input wire logic data_ack_pin,
    input wire logic pin_io_mode,
    input wire logic pin_gpo_select,
    output ssp_pkg::ssp_pins_t pins
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    generate
        if (DIV_W != ssp_pkg::SSP_DIV_W) begin : g_bad_div
            $error("divisor width must match the register field");
        end
    endgenerate

    ssp_pkg::ssp_regs_t r;
    ssp_pkg::ssp_regs_t next_r;

    logic hit_cmd;
    logic hit_data;
    logic hit_div;
    logic wr;
    logic rd;
    logic tick;
    logic edge_ev;
    logic sample;
    logic launch;
    logic [7:0] nrx;

    assign apb_rsp = r.rsp;
    assign pins = r.pins;

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        nrx = r.rx_shift_reg;
        sample = 1'b0;
        launch = 1'b0;
        tick = 1'b0;
        hit_cmd = apb_req.paddr == ssp_pkg::SSP_CMD_ADDR;
        hit_data = apb_req.paddr == ssp_pkg::SSP_DATA_ADDR;
        hit_div = apb_req.paddr == ssp_pkg::SSP_DIV_ADDR;
        wr = apb_req.psel & apb_req.penable & r.rsp.pready & apb_req.pwrite;
        rd = apb_req.psel & apb_req.penable & r.rsp.pready & ~apb_req.pwrite;

        // Half-period divider; each tick is one clock edge.
        if (r.div_cnt == 4'h0) begin
            tick = 1'b1;
            next_r.div_cnt = r.divisor_field; // [R3] [R4]
        end else begin
            next_r.div_cnt = r.div_cnt - 4'h1;
        end

        // Input clock is taken as synchronous, so one previous sample
        // is enough to see its edges.
        next_r.sclk_prev = serial_clock_in;
        if (r.slave_role_bit) begin
            edge_ev = serial_clock_in != r.sclk_prev; // [R2]
        end else begin
            edge_ev = (r.state == ssp_pkg::SSP_RUN) & tick; // [R2]
        end

        // Read of data clears the flag; a same-cycle set still wins below.
        if (rd && hit_data) begin
            next_r.full = 1'b0; // [R7]
        end

        if (edge_ev) begin
            // Phase 0 samples on even edges, phase 1 on odd ones.
            sample = r.edge_cnt[0] == r.clock_phase_bit; // [R12] [R13]
            if (r.clock_phase_bit) begin
                launch = ~sample & (r.edge_cnt != 4'h0); // [R12]
            end else begin
                launch = ~sample & (r.edge_cnt != ssp_pkg::SSP_LAST_EDGE);
            end
            if (!r.slave_role_bit) begin
                next_r.sclk_lvl = ~r.sclk_lvl; // [R3]
            end
            if (r.slave_role_bit && r.state == ssp_pkg::SSP_IDLE) begin
                next_r.state = ssp_pkg::SSP_RUN;
            end
            if (r.edge_cnt == ssp_pkg::SSP_LAST_EDGE) begin
                next_r.edge_cnt = 4'h0;
                next_r.state = ssp_pkg::SSP_IDLE; // [R14] [R20]
                next_r.pins.data_request_pin = 1'b0;
            end else begin
                next_r.edge_cnt = r.edge_cnt + 4'h1;
            end
        end

        if (sample) begin
            if (r.lsb_first_select) begin
                nrx = {rx_data_pin, r.rx_shift_reg[7:1]}; // [R10]
            end else begin
                nrx = {r.rx_shift_reg[6:0], rx_data_pin}; // [R10]
            end
            next_r.rx_shift_reg = nrx;
            next_r.bit_cnt = r.bit_cnt + 4'h1;
            if (r.bit_cnt == ssp_pkg::SSP_LAST_BIT) begin
                next_r.bit_cnt = 4'h0;
                next_r.rx_byte = nrx; // [R18] [R14]
                next_r.full = 1'b1; // [R18] [R9]
            end
        end

        if (launch) begin
            if (r.lsb_first_select) begin
                next_r.tx_shift_reg = r.tx_shift_reg >> 1; // [R10]
            end else begin
                next_r.tx_shift_reg = r.tx_shift_reg << 1; // [R10]
            end
        end

        // Master clock rests at the polarity level between transfers.
        if (r.state == ssp_pkg::SSP_IDLE && !edge_ev) begin
            next_r.sclk_lvl = r.clock_polarity_bit; // [R20] [R11]
        end

        // Slave handshake: request drops once the master acknowledges.
        if (data_ack_pin) begin
            next_r.pins.data_request_pin = 1'b0; // [R17]
        end

        // Register writes.
        if (wr && hit_cmd) begin
            next_r.slave_role_bit = apb_req.pwdata[ssp_pkg::SSP_ROLE_POS];
            next_r.clock_phase_bit = apb_req.pwdata[ssp_pkg::SSP_PHASE_POS];
            next_r.clock_polarity_bit = apb_req.pwdata[ssp_pkg::SSP_POL_POS];
            next_r.lsb_first_select = apb_req.pwdata[ssp_pkg::SSP_ORDER_POS];
            next_r.status_out_value =
                apb_req.pwdata[ssp_pkg::SSP_STATOUT_POS]; // [R16]
        end
        if (wr && hit_div) begin
            next_r.divisor_field = apb_req.pwdata[3:0]; // [R4]
            next_r.div_cnt = apb_req.pwdata[3:0]; // [R5]
        end
        if (wr && hit_data) begin
            next_r.tx_shift_reg = apb_req.pwdata[7:0]; // [R6]
            next_r.bit_cnt = 4'h0; // [R6]
            next_r.edge_cnt = 4'h0; // [R6]
            next_r.state = ssp_pkg::SSP_RUN; // [R6] [R20]
            next_r.div_cnt = r.divisor_field; // [R5]
            next_r.sclk_lvl = r.clock_polarity_bit;
            next_r.pins.data_request_pin = r.slave_role_bit; // [R17]
        end

        // APB answer: one access cycle, data prepared during setup.
        next_r.rsp.pready = apb_req.psel & ~apb_req.penable;
        next_r.rsp.pslverr = 1'b0;
        next_r.rsp.prdata = 32'h00000000; // [R19]
        if (apb_req.psel && !apb_req.penable) begin
            next_r.rsp.pslverr = ~(hit_cmd | hit_data | hit_div);
            if (hit_cmd) begin
                next_r.rsp.prdata[ssp_pkg::SSP_ROLE_POS] = r.slave_role_bit;
                next_r.rsp.prdata[ssp_pkg::SSP_PHASE_POS] =
                    r.clock_phase_bit;
                next_r.rsp.prdata[ssp_pkg::SSP_POL_POS] =
                    r.clock_polarity_bit;
                next_r.rsp.prdata[ssp_pkg::SSP_ORDER_POS] =
                    r.lsb_first_select;
                next_r.rsp.prdata[ssp_pkg::SSP_STATOUT_POS] =
                    r.status_out_value;
            end
            if (hit_data) begin
                next_r.rsp.prdata[7:0] = r.rx_byte; // [R7]
            end
            if (hit_div) begin
                next_r.rsp.prdata[3:0] = r.divisor_field;
                next_r.rsp.prdata[ssp_pkg::SSP_FULL_POS] = r.full; // [R8]
            end
        end

        // Pin outputs, registered from the next state.
        if (r.slave_role_bit) begin
            next_r.pins.serial_clock_oe = 1'b0; // [R2]
        end else begin
            next_r.pins.serial_clock_oe = 1'b1; // [R2]
        end
        if (pin_io_mode) begin
            next_r.pins.serial_clock_out = 1'b0; // [R11]
        end else begin
            next_r.pins.serial_clock_out = next_r.sclk_lvl; // [R11]
        end
        if (next_r.lsb_first_select) begin
            next_r.pins.tx_data_pin = next_r.tx_shift_reg[0]; // [R13]
        end else begin
            next_r.pins.tx_data_pin = next_r.tx_shift_reg[7]; // [R13]
        end
        if (pin_gpo_select) begin
            next_r.pins.port_status_pin = next_r.status_out_value; // [R16]
        end else begin
            next_r.pins.port_status_pin =
                next_r.state == ssp_pkg::SSP_IDLE;
        end
        next_r.pins.rx_full_flag = next_r.full; // [R8]
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // The flag is updated on the one system clock edge; there is no
    // second edge to use, so it lands at the first edge after the bit.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            r <= '0;
            r.state <= ssp_pkg::SSP_IDLE;
            r.divisor_field <= ssp_pkg::SSP_DIV_RST;
            r.rx_byte <= ssp_pkg::SSP_BYTE_RST;
            r.tx_shift_reg <= ssp_pkg::SSP_BYTE_RST; // [R1]
            r.pins.tx_data_pin <= 1'b0; // [R1]
            r.pins.port_status_pin <= 1'b1; // [R1]
            r.pins.serial_clock_oe <= 1'b1; // [R2]
        end else begin
            r <= next_r;
        end
    end

endmodule

// >>> tb/ssp_checker.sv
// Checker of the port's bus answers, pins and serial clock timing.
`timescale 1ns/1ps
module ssp_checker #(
    parameter int DIV_W = 4
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire ssp_pkg::ssp_apb_req_t apb_req,
    input wire ssp_pkg::ssp_apb_rsp_t apb_rsp,
    input wire logic rx_data_pin,
    input wire logic serial_clock_in,
    input wire logic data_ack_pin,
    input wire logic pin_io_mode,
    input wire logic pin_gpo_select,
    input wire ssp_pkg::ssp_pins_t pins
);
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    logic acc, rd, wr, wd, map, sq, tgl;
    logic [31:0] a;
    logic [8:0] cmd;
    logic [DIV_W-1:0] dv;
    logic [4:0] gap, ntg;
    assign a = apb_req.paddr;
    assign acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
    assign rd = acc && !apb_req.pwrite;
    assign wr = acc && apb_req.pwrite;
    assign wd = wr && a == ssp_pkg::SSP_DATA_ADDR;
    assign map = a == ssp_pkg::SSP_CMD_ADDR || a == ssp_pkg::SSP_DATA_ADDR
        || a == ssp_pkg::SSP_DIV_ADDR;
    assign tgl = pins.serial_clock_out != sq;
    // Shadows load on the same edge as the port's own registers.
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cmd <= 9'h000;
            dv <= '0;
            sq <= 1'b0;
            gap <= 5'h00;
            ntg <= 5'h00;
        end else begin
            sq <= pins.serial_clock_out;
            gap <= tgl ? 5'h01 : gap + 5'h01;
            if (wr && a == ssp_pkg::SSP_CMD_ADDR) begin
                cmd <= apb_req.pwdata[8:0];
            end
            if (wr && a == ssp_pkg::SSP_DIV_ADDR) begin
                dv <= apb_req.pwdata[DIV_W-1:0];
            end
            if (wd) begin
                ntg <= 5'h00;
            end else if (tgl && ntg != 5'h1f) begin
                ntg <= ntg + 5'h01;
            end
        end
    end
    AST_RDY: assert property (
        apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
        else $error("no ready after setup");
    AST_ERR: assert property (
        acc && !map |-> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_DIV_RD: assert property (
        rd && a == ssp_pkg::SSP_DIV_ADDR |-> apb_rsp.prdata[31:8] == 24'h0
        && apb_rsp.prdata[6:4] == 3'h0)
        else $error("unused divisor bits set");
    AST_IO_CLK: assert property (
        pin_io_mode |=> !pins.serial_clock_out)
        else $error("clock driven in io mode");
    AST_GPO: assert property (
        pin_gpo_select |=> pins.port_status_pin == cmd[8])
        else $error("status pin differs");
    AST_BIT1: assert property (
        wd |=> pins.tx_data_pin == ($past(cmd[4]) ?
        $past(apb_req.pwdata[0]) : $past(apb_req.pwdata[7])))
        else $error("wrong first bit");
    AST_GAP: assert property (
        tgl && ntg != 5'h00 && ntg < 5'h10 |-> gap == 5'(dv) + 5'h01)
        else $error("wrong half period");
    AST_EDGES: assert property (
        wd && !cmd[0] && !pin_io_mode |-> ##[17:600]
        ntg == 5'h10 && pins.serial_clock_out == cmd[3])
        else $error("wrong clock edge count");
    AST_FCLR: assert property (
        rd && a == ssp_pkg::SSP_DATA_ADDR && pins.rx_full_flag
        |=> ##1 !pins.rx_full_flag)
        else $error("full flag not cleared");
endmodule
bind ssp_sync_serial_port ssp_checker #(.DIV_W(DIV_W)) i_chk (
    .sys_clk, .sys_rst, .apb_req, .apb_rsp, .rx_data_pin,
    .serial_clock_in, .data_ack_pin, .pin_io_mode, .pin_gpo_select,
    .pins);

// >>> tb/ssp_peer.sv
// Behavioural peripheral on the far side of the serial link.
`timescale 1ns/1ps
module ssp_peer (
    input wire logic sclk,
    input wire logic sdi,
    input wire logic pol,
    input wire logic pha,
    input wire logic lsb,
    input wire logic [7:0] tx_byte,
    input wire logic arm,
    output logic sdo,
    output logic [7:0] got
);
    logic [7:0] sr;
    logic first, idle = 1'b0;
    int n = 8;
    // Released line shows the inverse, so a late sample cannot pass by luck.
    assign sdo = (n >= 8) ? idle : (lsb ? sr[0] : sr[7]);
    always @(arm) begin
        sr = tx_byte;
        n = 0;
        first = 1'b1;
    end
    always @(sclk) begin
        if (sclk === (pol ~^ pha)) begin
            got = lsb ? {sdi, got[7:1]} : {got[6:0], sdi};
            if (n == 7) idle = ~sdo;
            n = n + 1;
        end else if (pha && first) begin
            first = 1'b0;
        end else begin
            sr = lsb ? sr >> 1 : sr << 1;
        end
    end
endmodule

// >>> tb/ssp_sync_serial_port_test.sv
// Bench driving the serial port over its register bus and serial pins.
`timescale 1ns/1ps
module ssp_sync_serial_port_test;
    localparam logic [31:0] a_cmd = ssp_pkg::SSP_CMD_ADDR;
    localparam logic [31:0] a_dat = ssp_pkg::SSP_DATA_ADDR;
    localparam logic [31:0] a_div = ssp_pkg::SSP_DIV_ADDR;
    localparam logic [7:0] sb = 8'h4b;
    logic sys_clk = 1'b0, sys_rst = 1'b1, sci = 1'b0, iom = 1'b0;
    logic gpo = 1'b0, brx = 1'b0, slv = 1'b0, parm = 1'b0, psdo, err;
    logic ack = 1'b0;
    logic [2:0] pm = 3'h0;
    logic [7:0] pb = 8'h00, pgot;
    logic [31:0] q;
    ssp_pkg::ssp_apb_req_t req = '0;
    ssp_pkg::ssp_apb_rsp_t rsp;
    ssp_pkg::ssp_pins_t pins;
    int fails = 0, n_tests = 0;
    ssp_sync_serial_port i_dut (
        .sys_clk, .sys_rst, .apb_req(req), .apb_rsp(rsp),
        .rx_data_pin(slv ? brx : psdo), .serial_clock_in(sci),
        .data_ack_pin(ack), .pin_io_mode(iom), .pin_gpo_select(gpo),
        .pins);
    ssp_peer i_peer (
        .sclk(pins.serial_clock_out), .sdi(pins.tx_data_pin), .pol(pm[1]),
        .pha(pm[0]), .lsb(pm[2]), .tx_byte(pb), .arm(parm), .sdo(psdo),
        .got(pgot));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [31:0] a,
        input logic [31:0] d);
        int t;
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        t = 0;
        do begin
            @(posedge sys_clk);
            t++;
        end while (rsp.pready !== 1'b1 && t < 64);
        if (rsp.pready !== 1'b1) begin
            fails++;
        end
        q = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic wait_full;
        for (int t = 0; t < 1000 && pins.rx_full_flag !== 1'b1; t++) begin
            @(posedge sys_clk);
        end
        if (pins.rx_full_flag !== 1'b1) begin
            fails++;
        end
    endtask
    task automatic print_verdict;
        $display("%0d compared, %0d wrong", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
    initial begin
        repeat (20) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk(32'(pins), 32'h0000000a);
        rd(a_cmd, 32'h0);
        rd(a_div, 32'h0);
        $display("reset test done");
        for (int m = 0; m < 8; m++) begin
            pm <= m[2:0];
            pb <= 8'h3c ^ 8'(m * 37);
            apb(1'b1, a_cmd, {27'h0, m[2:0], 2'b00});
            apb(1'b1, a_div, 32'(m));
            parm <= ~parm;
            apb(1'b1, a_dat, 32'(8'hc5 ^ 8'(m)));
            wait_full();
            rd(a_div, 32'h80 | 32'(m));
            rd(a_dat, {24'h0, pb});
            chk({24'h0, pgot}, 32'(8'hc5 ^ 8'(m)));
            rd(a_div, 32'(m));
        end
        $display("transfer test done");
        apb(1'b1, a_cmd + 32'h4, 32'hffff_ffff);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, a_cmd, 32'hffff_ffff);
        rd(a_cmd, 32'h0000011d);
        chk({31'h0, pins.serial_clock_oe}, 32'h0);
        gpo <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, pins.port_status_pin}, 32'h1);
        apb(1'b1, a_cmd, 32'h0);
        chk({31'h0, pins.port_status_pin}, 32'h0);
        gpo <= 1'b0;
        apb(1'b1, a_div, 32'hffff_ffff);
        rd(a_div, 32'h0000000f);
        apb(1'b1, a_cmd, 32'h8);
        chk({31'h0, pins.serial_clock_out}, 32'h1);
        iom <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, pins.serial_clock_out}, 32'h0);
        iom <= 1'b0;
        $display("register test done");
        slv <= 1'b1;
        apb(1'b1, a_cmd, 32'h1);
        apb(1'b1, a_dat, 32'h96);
        chk({31'h0, pins.data_request_pin}, 32'h1);
        for (int i = 7; i >= 0; i--) begin
            brx <= sb[i];
            repeat (4) @(posedge sys_clk);
            sci <= 1'b1;
            repeat (4) @(posedge sys_clk);
            sci <= 1'b0;
        end
        brx <= ~brx;
        // The last clock edge is seen one cycle later, so let it land.
        repeat (2) @(posedge sys_clk);
        wait_full();
        chk({31'h0, pins.data_request_pin}, 32'h0);
        rd(a_dat, {24'h0, sb});
        apb(1'b1, a_dat, 32'h5a);
        chk({31'h0, pins.data_request_pin}, 32'h1);
        ack <= 1'b1;
        @(posedge sys_clk);
        ack <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, pins.data_request_pin}, 32'h0);
        $display("slave test done");
        print_verdict();
    end
endmodule
